// >>> timer8_pwm_pkg.sv
// constants, register map and bus carrier for the 8-bit waveform timer
// assumes a single 40 mhz clock and a plain strobe register port

package timer8_pwm_pkg;

    // ----------------------------------------
    // register indices
    // ----------------------------------------
    localparam logic [2:0] ADDR_CTRL_A = 3'h0;
    localparam logic [2:0] ADDR_CTRL_B = 3'h1;
    localparam logic [2:0] ADDR_COUNT = 3'h2;
    localparam logic [2:0] ADDR_CMP_A = 3'h3;
    localparam logic [2:0] ADDR_CMP_B = 3'h4;
    localparam logic [2:0] ADDR_FLAGS = 3'h5;
    localparam logic [2:0] ADDR_PIN_DIR = 3'h6;

    // ----------------------------------------
    // field positions and values
    // ----------------------------------------
    localparam int ACT_A_LSB = 6;
    localparam int ACT_B_LSB = 4;
    localparam int HIGH_MODE_POS = 3;
    localparam int FLAG_OVF = 0;
    localparam int FLAG_MATCH_A = 1;
    localparam int FLAG_MATCH_B = 2;
    localparam logic [7:0] RESET_BYTE = 8'h00;
    localparam logic [7:0] COUNT_MAX = 8'hff;
    localparam logic [7:0] COUNT_BOTTOM = 8'h00;

    // ----------------------------------------
    // prescaler taps, cycles minus one
    // ----------------------------------------
    localparam int PRESCALE_W = 10;
    localparam logic [9:0] DIV8_MASK = 10'h007;
    localparam logic [9:0] DIV64_MASK = 10'h03f;
    localparam logic [9:0] DIV256_MASK = 10'h0ff;
    localparam logic [9:0] DIV1024_MASK = 10'h3ff;

    typedef enum logic [2:0] {
        SEL_STOP,
        SEL_DIV1,
        SEL_DIV8,
        SEL_DIV64,
        SEL_DIV256,
        SEL_DIV1024,
        SEL_EXT_FALL,
        SEL_EXT_RISE
    } tick_sel_t;

    typedef struct packed {
        logic [2:0] addr;
        logic [7:0] wdata;
        logic we;
        logic re;
    } reg_req_t;

endpackage

// >>> timer8_pwm_waveform_unit.sv
// 8-bit timer with fast and dual-slope pwm on two compare outputs
// assumes the register master keeps strobes one cycle and never both
//
// Added by the designer: the register addresses and the plain strobed port.

module timer8_pwm_waveform_unit
    import timer8_pwm_pkg::*;
(
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // register port
    input wire reg_req_t reg_req,
    output logic [7:0] reg_rdata,
    // external count pin
    input wire logic ext_tick_pin,
    // compare outputs
    output logic wave_out_a,
    output logic wave_out_a_oe,
    output logic wave_out_b,
    output logic wave_out_b_oe
);

    // ----------------------------------------
    // registers
    // ----------------------------------------
    logic [7:0] ctrl_a_q;
    logic [3:0] ctrl_b_q;
    logic [7:0] count_q;
    logic [7:0] buf_a_q;
    logic [7:0] buf_b_q;
    logic [7:0] act_a_q;
    logic [7:0] act_b_q;
    logic [2:0] flags_q;
    logic [1:0] pin_dir_q;
    logic [1:0] wave_q;
    logic [1:0] seen_q;
    logic up_q;
    logic [7:0] rdata_q;
    logic [PRESCALE_W-1:0] pre_q;
    logic [2:0] ext_sync_q;
    logic ext_lvl_q;
    logic ext_agree;

    logic [1:0] out_action_a;
    logic [1:0] out_action_b;
    logic [2:0] wave_mode_sel;
    tick_sel_t tick_source_sel;
    logic timer_tick;
    logic fast;
    logic pc;
    logic ctc;
    logic [7:0] top;
    logic wr_count;
    logic at_max;
    logic wrap;
    logic at_top;
    logic at_bot;
    logic eq_a;
    logic eq_b;
    logic [7:0] count_d;

    assign out_action_a = ctrl_a_q[ACT_A_LSB+:2];
    assign out_action_b = ctrl_a_q[ACT_B_LSB+:2];
    assign wave_mode_sel = {ctrl_b_q[HIGH_MODE_POS], ctrl_a_q[1:0]};
    assign tick_source_sel = tick_sel_t'(ctrl_b_q[2:0]);

    assign fast = (wave_mode_sel[1:0] == 2'b11);
    assign pc = (wave_mode_sel[1:0] == 2'b01);
    // 4 and 6 fall through to normal
    assign ctc = (wave_mode_sel == 3'h2);
    assign top = wave_mode_sel[2] ? act_a_q : COUNT_MAX;

    assign wr_count = reg_req.we && (reg_req.addr == ADDR_COUNT);
    assign at_max = (count_q == top);
    assign wrap = timer_tick && fast && at_max;
    assign at_top = timer_tick && pc && up_q && at_max;
    assign at_bot = timer_tick && pc && !up_q && (count_q == COUNT_BOTTOM);
    assign eq_a = timer_tick && (count_q == act_a_q);
    assign eq_b = timer_tick && (count_q == act_b_q);

    // ----------------------------------------
    // tick generation
    // ----------------------------------------
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            pre_q <= '0;
        end
        else
        begin
            pre_q <= pre_q + 1'b1;
        end
    end

    // first stage feeds only the second
    // a pin change counts once stages two and three agree
    assign ext_agree = (ext_sync_q[2] == ext_sync_q[1]);

    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            ext_sync_q <= 3'h0;
            ext_lvl_q <= 1'b0;
        end
        else
        begin
            ext_sync_q <= {ext_sync_q[1:0], ext_tick_pin};
            if (ext_agree)
            begin
                ext_lvl_q <= ext_sync_q[2];
            end
        end
    end

    // tick is an enable on sys_clk
    always_comb
    begin
        case (tick_source_sel)
            SEL_STOP: timer_tick = 1'b0;
            SEL_DIV1: timer_tick = 1'b1;
            SEL_DIV8: timer_tick = (pre_q[2:0] == DIV8_MASK[2:0]);
            SEL_DIV64: timer_tick = (pre_q[5:0] == DIV64_MASK[5:0]);
            SEL_DIV256: timer_tick = (pre_q[7:0] == DIV256_MASK[7:0]);
            SEL_DIV1024: timer_tick = (pre_q == DIV1024_MASK);
            SEL_EXT_FALL: timer_tick = ext_agree && ext_lvl_q && !ext_sync_q[2];
            SEL_EXT_RISE: timer_tick = ext_agree && !ext_lvl_q && ext_sync_q[2];
            default: timer_tick = 1'b0;
        endcase
    end

    // ----------------------------------------
    // control registers
    // ----------------------------------------
    // layout, bits 3:2 stay zero
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            ctrl_a_q <= RESET_BYTE;
            ctrl_b_q <= 4'h0;
            pin_dir_q <= 2'h0;
        end
        else if (reg_req.we)
        begin
            case (reg_req.addr)
                ADDR_CTRL_A: ctrl_a_q <= reg_req.wdata & 8'hf3;
                ADDR_CTRL_B: ctrl_b_q <= reg_req.wdata[3:0];
                ADDR_PIN_DIR: pin_dir_q <= reg_req.wdata[1:0];
                default: ctrl_a_q <= ctrl_a_q;
            endcase
        end
    end

    // ----------------------------------------
    // compare buffers
    // ----------------------------------------
    // active value loads at top in pwm
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            buf_a_q <= RESET_BYTE;
            buf_b_q <= RESET_BYTE;
            act_a_q <= RESET_BYTE;
            act_b_q <= RESET_BYTE;
        end
        else
        begin
            if (reg_req.we && reg_req.addr == ADDR_CMP_A)
            begin
                buf_a_q <= reg_req.wdata;
            end
            if (reg_req.we && reg_req.addr == ADDR_CMP_B)
            begin
                buf_b_q <= reg_req.wdata;
            end
            if (!(fast || pc) || wrap || at_top)
            begin
                act_a_q <= buf_a_q;
                act_b_q <= buf_b_q;
            end
        end
    end

    // ----------------------------------------
    // counter
    // ----------------------------------------
    always_comb
    begin
        count_d = count_q + 8'h01;
        if (fast)
        begin
            // 256 ticks when top is 0xff
            if (at_max)
            begin
                count_d = COUNT_BOTTOM;
            end
        end
        else if (pc)
        begin
            if (up_q && at_max)
            begin
                count_d = count_q - 8'h01;
            end
            else if (!up_q && count_q == COUNT_BOTTOM)
            begin
                count_d = 8'h01;
            end
            else if (!up_q)
            begin
                count_d = count_q - 8'h01;
            end
        end
        else if (ctc && count_q == act_a_q)
        begin
            count_d = COUNT_BOTTOM;
        end
    end

    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            count_q <= COUNT_BOTTOM;
            up_q <= 1'b1;
        end
        else if (wr_count)
        begin
            count_q <= reg_req.wdata;
        end
        else if (timer_tick)
        begin
            count_q <= count_d;
            if (!pc || at_bot)
            begin
                up_q <= 1'b1;
            end
            else if (at_top)
            begin
                up_q <= 1'b0;
            end
        end
    end

    // ----------------------------------------
    // flags, set wins over clear
    // ----------------------------------------
    logic ovf_evt;

    assign ovf_evt = fast ? wrap : (pc ? at_bot : (timer_tick && count_q == COUNT_MAX));

    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            flags_q <= 3'h0;
        end
        else
        begin
            if (reg_req.we && reg_req.addr == ADDR_FLAGS)
            begin
                flags_q <= flags_q & ~reg_req.wdata[2:0];
            end
            if (ovf_evt)
            begin
                flags_q[FLAG_OVF] <= 1'b1;
            end
            if (eq_a)
            begin
                flags_q[FLAG_MATCH_A] <= 1'b1;
            end
            if (eq_b)
            begin
                flags_q[FLAG_MATCH_B] <= 1'b1;
            end
        end
    end

    // ----------------------------------------
    // waveform next state
    // ----------------------------------------
    function automatic logic wave_next(
        input logic cur,
        input logic [1:0] act,
        input logic tog_ok,
        input logic eq,
        input logic ovr,
        input logic zero,
        input logic seen
    );
        logic r;
        r = cur;
        if (fast || pc)
        begin
            if (act == 2'b01 && tog_ok && eq)
            begin
                r = !cur;
            end
            else if (act[1] && fast)
            begin
                // action 10 sets at bottom and clears on match, 11 the reverse
                if (wrap)
                begin
                    r = !act[0];
                end
                else if (eq && !ovr)
                begin
                    r = act[0];
                end
            end
            else if (act[1])
            begin
                if (at_top && ovr)
                begin
                    r = !act[0];
                end
                else if (at_top && !seen)
                begin
                    r = act[0];
                end
                else if (at_bot)
                begin
                    r = zero ? act[0] : !act[0];
                end
                else if (eq && !ovr)
                begin
                    r = up_q ? act[0] : !act[0];
                end
            end
        end
        else if (eq)
        begin
            case (act)
                2'b01: r = !cur;
                2'b10: r = 1'b0;
                2'b11: r = 1'b1;
                default: r = cur;
            endcase
        end
        return r;
    endfunction

    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            wave_q <= 2'h0;
            seen_q <= 2'h0;
        end
        else
        begin
            wave_q[0] <= wave_next(wave_q[0], out_action_a, wave_mode_sel[2], eq_a,
                (act_a_q == top), (act_a_q == COUNT_BOTTOM), seen_q[0]);
            wave_q[1] <= wave_next(wave_q[1], out_action_b, 1'b0, eq_b,
                (act_b_q == top), (act_b_q == COUNT_BOTTOM), seen_q[1]);
            if (at_bot)
            begin
                seen_q <= 2'h0;
            end
            else if (pc && up_q)
            begin
                seen_q <= seen_q | {eq_b, eq_a};
            end
        end
    end

    // override when action set, driver by direction
    assign wave_out_a = wave_q[0];
    assign wave_out_b = wave_q[1];
    assign wave_out_a_oe = (out_action_a != 2'b00) && pin_dir_q[0];
    assign wave_out_b_oe = (out_action_b != 2'b00) && pin_dir_q[1];

    // ----------------------------------------
    // read port
    // ----------------------------------------
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            rdata_q <= RESET_BYTE;
        end
        else if (reg_req.re)
        begin
            case (reg_req.addr)
                ADDR_CTRL_A: rdata_q <= ctrl_a_q;
                ADDR_CTRL_B: rdata_q <= {4'h0, ctrl_b_q};
                ADDR_COUNT: rdata_q <= count_q;
                ADDR_CMP_A: rdata_q <= buf_a_q;
                ADDR_CMP_B: rdata_q <= buf_b_q;
                ADDR_FLAGS: rdata_q <= {5'h00, flags_q};
                ADDR_PIN_DIR: rdata_q <= {6'h00, pin_dir_q};
                default: rdata_q <= RESET_BYTE;
            endcase
        end
        else
        begin
            rdata_q <= RESET_BYTE;
        end
    end

    assign reg_rdata = rdata_q;

    // ----------------------------------------
    // assertions
    // ----------------------------------------
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (rst);

    sequence div8_tick;
        tick_source_sel == SEL_DIV8 && timer_tick;
    endsequence

    // a switch of tick source may legally tick early
    sequence div8_quiet;
        (!timer_tick || tick_source_sel != SEL_DIV8) [*7];
    endsequence

    a_fast_wrap_zero: assert property (wrap && !wr_count |=> count_q == COUNT_BOTTOM)
        else $error("fast mode did not wrap to zero");
    a_fast_top_flag: assert property (wrap |=> flags_q[FLAG_OVF])
        else $error("fast overflow flag not set at top");
    a_pc_bottom_flag: assert property (at_bot |=> flags_q[FLAG_OVF])
        else $error("dual-slope overflow flag not set at bottom");
    a_pc_top_turn: assert property (at_top && !wr_count |=> !up_q && count_q == $past(top) - 8'h01)
        else $error("dual-slope did not turn at top");
    a_fast_bottom_set: assert property (fast && out_action_a == 2'b10 && wrap |=> wave_out_a)
        else $error("non-inverted output not set at bottom");
    a_pin_enable: assert property (wave_out_a_oe == (pin_dir_q[0] && out_action_a != 2'b00))
        else $error("pin enable does not follow action and direction");
    a_ctrl_reserved: assert property ($past(reg_req.re) && $past(reg_req.addr) == ADDR_CTRL_A |-> reg_rdata[3:2] == 2'b00)
        else $error("reserved control bits read nonzero");
    a_tick_div8: assert property (div8_tick ##1 tick_source_sel == SEL_DIV8 |-> div8_quiet)
        else $error("divide-by-eight tick too close");
    a_tick_stopped: assert property (tick_source_sel == SEL_STOP |-> !timer_tick)
        else $error("tick while stopped");
    // channel b never toggles in pwm
    a_b_no_toggle: assert property ((fast || pc) && out_action_b == 2'b01 |=> $stable(wave_out_b))
        else $error("channel b toggled in pwm");

endmodule

// >>> test_timer8_pwm_waveform_unit.sv
// self-checking bench for the 8-bit fast and dual-slope pwm timer
// assumes the register port and constants of timer8_pwm_pkg, 40 mhz clock

`define check_eq(got, exp) \
    begin \
        comparisons++; \
        if ((got) !== (exp)) \
        begin \
            err_total++; \
            $display("wrong value at %0t: got %h expected %h", $time, got, exp); \
        end \
    end

module test_timer8_pwm_waveform_unit
    import timer8_pwm_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;

    // ----------------------------------------
    // signals and instance
    // ----------------------------------------
    logic sys_clk;
    logic rst;
    reg_req_t req;
    logic [7:0] rdata;
    logic ext_tick_pin;
    logic wave_out_a;
    logic wave_out_a_oe;
    logic wave_out_b;
    logic wave_out_b_oe;
    int err_total = 0;
    int comparisons = 0;

    timer8_pwm_waveform_unit timer8_pwm_waveform_unit_inst (
        .sys_clk(sys_clk),
        .rst(rst),
        .reg_req(req),
        .reg_rdata(rdata),
        .ext_tick_pin(ext_tick_pin),
        .wave_out_a(wave_out_a),
        .wave_out_a_oe(wave_out_a_oe),
        .wave_out_b(wave_out_b),
        .wave_out_b_oe(wave_out_b_oe)
    );

    initial
    begin
        sys_clk = 1'b0;
        forever #12.5 sys_clk = ~sys_clk;
    end

    // ----------------------------------------
    // bus and sampling helpers
    // ----------------------------------------
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        req <= '{addr: a, wdata: d, we: 1'b1, re: 1'b0};
        @(posedge sys_clk);
        req.we <= 1'b0;
    endtask

    task automatic rd(input logic [2:0] a, output logic [7:0] d);
        @(posedge sys_clk);
        req <= '{addr: a, wdata: 8'h00, we: 1'b0, re: 1'b1};
        @(posedge sys_clk);
        req.re <= 1'b0;
        #1;
        d = rdata;
    endtask

    task automatic rd_chk(input logic [2:0] a, input logic [7:0] exp);
        logic [7:0] d;
        rd(a, d);
        `check_eq(d, exp)
    endtask

    task automatic sample(input bit b, output logic w);
        @(posedge sys_clk);
        #1;
        w = b ? wave_out_b : wave_out_a;
    endtask

    // stopped and normal mode first, so compares load at once
    task automatic cfg(input logic [7:0] ca, cb, cmpa, cmpb);
        wr(ADDR_CTRL_B, 8'h00);
        wr(ADDR_CTRL_A, 8'h00);
        wr(ADDR_COUNT, 8'h00);
        wr(ADDR_CMP_A, cmpa);
        wr(ADDR_CMP_B, cmpb);
        wr(ADDR_CTRL_A, ca);
        wr(ADDR_CTRL_B, cb);
    endtask

    task automatic wait_rise(input bit b);
        logic w;
        logic prev;
        int n;
        prev = 1'b1;
        for (n = 0; n < 5000; n++)
        begin
            sample(b, w);
            if (w === 1'b1 && prev === 1'b0)
                break;
            prev = w;
        end
    endtask

    // high time and period in clocks, from one rising edge to the next
    task automatic meas(input bit b, output int hi, output int per);
        logic w;
        int n;
        wait_rise(b);
        hi = 1;
        for (n = 0; n < 5000; n++)
        begin
            sample(b, w);
            if (w !== 1'b1)
                break;
            hi++;
        end
        per = hi + 1;
        for (n = 0; n < 5000; n++)
        begin
            sample(b, w);
            if (w === 1'b1)
                break;
            per++;
        end
    endtask

    // skip one full dual-slope period so start-up edges settle
    task automatic steady(input bit b, output logic lvl);
        logic w;
        int good;
        good = 0;
        repeat (520) @(posedge sys_clk);
        sample(b, lvl);
        repeat (520)
        begin
            sample(b, w);
            if (w === lvl)
                good++;
        end
        `check_eq(good, 520)
    endtask

    task automatic ovf(input int w1, input int w2);
        logic [7:0] d;
        wait_rise(1'b0);
        wr(ADDR_FLAGS, 8'h01);
        rd(ADDR_FLAGS, d);
        `check_eq(d[FLAG_OVF], 1'b0)
        repeat (w1) @(posedge sys_clk);
        rd(ADDR_FLAGS, d);
        `check_eq(d[FLAG_OVF], 1'b0)
        repeat (w2) @(posedge sys_clk);
        rd(ADDR_FLAGS, d);
        `check_eq(d[FLAG_OVF], 1'b1)
    endtask

    task automatic step(input logic [7:0] ca, cb, exp);
        logic [7:0] d1;
        logic [7:0] d2;
        cfg(ca, cb, 8'h03, 8'h03);
        rd(ADDR_COUNT, d1);
        rd(ADDR_COUNT, d2);
        `check_eq(8'(d2 - d1), exp)
    endtask

    task automatic ext_count(input logic [7:0] cb);
        cfg(8'h00, cb, 8'h00, 8'h00);
        repeat (5)
        begin
            @(posedge sys_clk);
            ext_tick_pin <= 1'b1;
            repeat (4) @(posedge sys_clk);
            ext_tick_pin <= 1'b0;
            repeat (4) @(posedge sys_clk);
        end
        repeat (6) @(posedge sys_clk);
        rd_chk(ADDR_COUNT, 8'h05);
    endtask

    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic test_regs;
        `check_eq(wave_out_a, 1'b0)
        `check_eq(wave_out_b, 1'b0)
        rd_chk(ADDR_CTRL_A, RESET_BYTE);
        rd_chk(ADDR_FLAGS, 8'h00);
        wr(ADDR_CTRL_A, 8'hff);
        rd_chk(ADDR_CTRL_A, 8'hf3);
        wr(ADDR_CTRL_B, 8'hff);
        rd_chk(ADDR_CTRL_B, 8'h0f);
        rd_chk(3'h7, 8'h00);
        wr(ADDR_CTRL_B, 8'h00);
        wr(ADDR_PIN_DIR, 8'h00);
        wr(ADDR_CTRL_A, 8'h80);
        @(posedge sys_clk);
        #1;
        `check_eq(wave_out_a_oe, 1'b0)
        wr(ADDR_PIN_DIR, 8'h03);
        @(posedge sys_clk);
        #1;
        `check_eq(wave_out_a_oe, 1'b1)
        `check_eq(wave_out_b_oe, 1'b0)
    endtask

    task automatic test_fast;
        int hi;
        int per;
        logic w;
        cfg(8'h83, 8'h01, 8'h80, 8'h00);
        meas(1'b0, hi, per);
        `check_eq(per, 256)
        `check_eq(hi, 129)
        ovf(140, 120);
        cfg(8'hc3, 8'h01, 8'h80, 8'h00);
        meas(1'b0, hi, per);
        `check_eq(hi, 127)
        cfg(8'h83, 8'h02, 8'h80, 8'h00);
        meas(1'b0, hi, per);
        `check_eq(per, 2048)
        `check_eq(hi, 1032)
        cfg(8'h23, 8'h09, 8'h09, 8'h03);
        meas(1'b1, hi, per);
        `check_eq(per, 10)
        `check_eq(hi, 4)
        cfg(8'h83, 8'h01, 8'h00, 8'h00);
        meas(1'b0, hi, per);
        `check_eq(hi, 1)
        cfg(8'h83, 8'h01, 8'hff, 8'h00);
        steady(1'b0, w);
        `check_eq(w, 1'b1)
        cfg(8'hc3, 8'h01, 8'hff, 8'h00);
        steady(1'b0, w);
        `check_eq(w, 1'b0)
        cfg(8'h43, 8'h09, 8'h00, 8'h00);
        meas(1'b0, hi, per);
        `check_eq(per, 2)
        cfg(8'h43, 8'h01, 8'h10, 8'h00);
        steady(1'b0, w);
        cfg(8'h13, 8'h09, 8'h09, 8'h02);
        steady(1'b1, w);
        cfg(8'h23, 8'h09, 8'h09, 8'h09);
        steady(1'b1, w);
        `check_eq(w, 1'b1)
    endtask

    task automatic test_dual;
        int hi;
        int per;
        logic w;
        cfg(8'h81, 8'h01, 8'h80, 8'h00);
        meas(1'b0, hi, per);
        `check_eq(per, 510)
        ovf(60, 100);
        cfg(8'h21, 8'h09, 8'h0a, 8'h04);
        meas(1'b1, hi, per);
        `check_eq(per, 20)
        cfg(8'h81, 8'h01, 8'h00, 8'h00);
        steady(1'b0, w);
        `check_eq(w, 1'b0)
        cfg(8'h81, 8'h01, 8'hff, 8'h00);
        steady(1'b0, w);
        `check_eq(w, 1'b1)
        cfg(8'hc1, 8'h01, 8'h00, 8'h00);
        steady(1'b0, w);
        `check_eq(w, 1'b1)
        cfg(8'h11, 8'h09, 8'h0a, 8'h04);
        steady(1'b1, w);
    endtask

    task automatic test_misc;
        int hi;
        int per;
        cfg(8'h42, 8'h01, 8'h03, 8'h00);
        meas(1'b0, hi, per);
        `check_eq(per, 8)
        cfg(8'h42, 8'h09, 8'h03, 8'h00);
        meas(1'b0, hi, per);
        `check_eq(per, 512)
        `check_eq(hi, 256)
        step(8'h00, 8'h00, 8'h00);
        step(8'h00, 8'h09, 8'h02);
        step(8'h02, 8'h09, 8'h02);
        ext_count(8'h07);
        ext_count(8'h06);
        cfg(8'h83, 8'h01, 8'hff, 8'h00);
        repeat (300) @(posedge sys_clk);
        rst <= 1'b1;
        @(posedge sys_clk);
        #1;
        `check_eq(wave_out_a, 1'b0)
        `check_eq(wave_out_a_oe, 1'b0)
        rst <= 1'b0;
        rd_chk(ADDR_CTRL_A, 8'h00);
    endtask

    // ----------------------------------------
    // run control
    // ----------------------------------------
    task automatic end_of_test;
        $display("checks %0d, mismatches %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    // whole run needs about 20k clocks
    initial
    begin
        repeat (80000) @(posedge sys_clk);
        err_total++;
        end_of_test;
    end

    initial
    begin
        rst = 1'b1;
        req = '0;
        ext_tick_pin = 1'b0;
        repeat (6) @(posedge sys_clk);
        rst <= 1'b0;
        test_regs;
        test_fast;
        test_dual;
        test_misc;
        end_of_test;
    end
endmodule
